// [core/shq_pkg.sv]
// Purpose: Shared constants and types for the sync and sample quality block
// Assumes: 25 MHz system clock, signed sample words, time offsets in ns
// Notes:   Register offsets are byte addresses on the plain register port
package shq_pkg;

	// Clock and timing
	localparam int unsigned CLK_HZ        = 25_000_000;  // System clock rate
	localparam int unsigned TICK_HZ       = 1_000;       // Millisecond tick
	localparam int unsigned TICK_DIV      = CLK_HZ / TICK_HZ;
	localparam int unsigned HOLD_S        = 60;          // Holdover length, s
	localparam int unsigned HOLD_TICKS    = HOLD_S * TICK_HZ;
	localparam int unsigned STEP_MS       = 5;           // Step or slew limit
	localparam logic [31:0] STEP_NS       = 32'(STEP_MS * 1_000_000);
	localparam logic [31:0] LOCK_ZONE_NS  = 32'h0000_03e8; // Locked zone, ns

	// Sample stream
	localparam int unsigned NCH           = 8;           // Analogue channels
	localparam int unsigned SW            = 24;          // Sample width
	localparam logic [23:0] RANGE_MULT    = 24'h00_0028; // 40 x nominal
	localparam logic [15:0] NOMINAL_RST   = 16'h1000;    // Nominal, reset

	// Register map
	localparam int unsigned AW            = 8;
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_NOMINAL    = 8'h04;
	localparam logic [7:0] REG_STATUS     = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT   = 8'h0c;
	localparam logic [7:0] REG_IRQ_MASK   = 8'h10;
	localparam logic [7:0] REG_RANGE      = 8'h14;

	// Control bits
	localparam int unsigned CTRL_CFG_BIT  = 0;   // Write 1: config received

	// Interrupt bit positions
	localparam int unsigned IRQ_HOLD      = 0;   // Entered holdover
	localparam int unsigned IRQ_FREE      = 1;   // Sync-not-locked alarm
	localparam int unsigned IRQ_RANGE     = 2;   // A sample was clipped
	localparam int unsigned IRQ_LOCK      = 3;   // Reached locked state
	localparam int unsigned IRQ_W         = 4;
	localparam logic [3:0] IRQ_MASK_RST   = 4'h0;

	// Sync state machine
	typedef enum logic [1:0] {
		SHQ_FREE   = 2'b00,  // Free running, sync not locked
		SHQ_SLEW   = 2'b01,  // Gradual pulse adjustment
		SHQ_LOCKED = 2'b10,  // Locked to the reference
		SHQ_HOLD   = 2'b11   // Sync lost, still reported locked
	} shq_sync_state_t;

	// Sample sync source field
	typedef enum logic [1:0] {
		SHQ_SRC_NONE   = 2'b00,
		SHQ_SRC_LOCAL  = 2'b01,
		SHQ_SRC_GLOBAL = 2'b10
	} shq_src_t;

	// Health status
	typedef enum logic [1:0] {
		SHQ_OK      = 2'b00,
		SHQ_WARNING = 2'b01,
		SHQ_ALARM   = 2'b10
	} shq_health_t;

	localparam logic [7:0] CLASS_GLOBAL   = 8'h06; // Always global
	localparam logic [7:0] CLASS_TRACE    = 8'h07; // Global if traceable

endpackage : shq_pkg

// [core/shq_smp_if.sv]
// Purpose: Carries the sample stream between the top and the clip stage
// Assumes: One sample set per valid cycle, all channels together
// Notes:   Clip stage output is registered
`timescale 1ns/1ps
interface shq_smp_if;
	import shq_pkg::*;

	logic                          in_valid;  // New sample set
	logic signed [NCH-1:0][SW-1:0] in_data;   // Raw readings
	logic        [SW-1:0]          limit;     // Positive full scale
	logic                          out_valid; // Processed set ready
	logic signed [NCH-1:0][SW-1:0] out_data;  // Clipped values
	logic        [NCH-1:0]         exceeded;  // Range exceeded per channel
	logic        [NCH-1:0]         quest;     // Questionable per channel

	modport src (output in_valid, in_data, limit,
	             input  out_valid, out_data, exceeded, quest);
	modport clip (input  in_valid, in_data, limit,
	              output out_valid, out_data, exceeded, quest);

endinterface : shq_smp_if

// [core/shq_tick.sv]
// Purpose: Divides the system clock into a one-cycle enable pulse
// Assumes: DIV of at least 2
// Notes:   Pulse stands one clock every DIV clocks
`timescale 1ns/1ps
module shq_tick #(
	parameter int unsigned DIV = 25_000
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Enable out
	output logic      tick
);

	logic [31:0] count;  // Cycles since last pulse

	// Free running divider
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count <= 32'h0000_0000;
			tick  <= 1'b0;
		end else if (count == 32'(DIV - 1)) begin
			count <= 32'h0000_0000;
			tick  <= 1'b1;
		end else begin
			count <= count + 32'h0000_0001;
			tick  <= 1'b0;
		end
	end

endmodule : shq_tick

// [core/shq_clip.sv]
// Purpose: Clips each channel at full scale and marks its quality
// Assumes: Limit is the positive full scale, symmetric about zero
// Notes:   One register stage; flags follow each sample set
`timescale 1ns/1ps
module shq_clip
	import shq_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Sample stream
	shq_smp_if.clip   smp
);

	// Valid follows the input by one cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			smp.out_valid <= 1'b0;
		end else begin
			smp.out_valid <= smp.in_valid;
		end
	end

	// One clip stage per channel
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic signed [SW-1:0] neg_lim;  // Negative full scale
		logic                 over_pos; // Above positive scale
		logic                 over_neg; // Below negative scale

		assign neg_lim  = -$signed(smp.limit);
		assign over_pos = $signed(smp.in_data[c]) > $signed(smp.limit);
		assign over_neg = $signed(smp.in_data[c]) < neg_lim;

		// Flags clear on the first in-range sample after a clip
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				smp.out_data[c] <= '0;
				smp.exceeded[c] <= 1'b0;
				smp.quest[c]    <= 1'b0;
			end else if (smp.in_valid) begin
				smp.exceeded[c] <= over_pos | over_neg;
				smp.quest[c]    <= over_pos | over_neg;
				if (over_pos) begin
					smp.out_data[c] <= $signed(smp.limit);
				end else if (over_neg) begin
					// Sign kept so the waveform still shows its direction
					smp.out_data[c] <= neg_lim;
				end else begin
					smp.out_data[c] <= smp.in_data[c];
				end
			end
		end
	end

endmodule : shq_clip

// [core/shq_top.sv]
// Purpose: Sync state tracking and sample quality marking for a merging unit
// Assumes: Inputs synchronous to clk; time_diff_ns is internal minus
//          received time, valid whenever sync_present is high
// Notes:   Register read data stand only in the cycle after the read strobe
//
// Overview of operation
// - Flag readings above forty times nominal
// - Send full scale while out of range
// - Range-exceeded flag makes quality questionable
// - Sync loss: sixty seconds holdover, still locked
// - Holdover expiry: free running, not-locked alarm
// - Difference below 5 ms: slew pulse gradually
// - Difference above 5 ms: single phase step
// - Sync field none, local or global
// - No operation before first configuration
// - Questionable sample drives health to warning
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module shq_top
	import shq_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_DIV,   // Clocks per ms tick
	parameter int unsigned HOLD_LEN    = HOLD_TICKS  // Holdover in ticks
) (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          nrst,
	// Register port
	input  wire logic [AW-1:0]                 reg_addr,
	input  wire logic [31:0]                   reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [31:0]                   reg_rdata,
	output logic                               irq,
	// Acquisition input
	input  wire logic                          smp_in_valid,
	input  wire logic signed [NCH-1:0][SW-1:0] smp_in,
	// Time source
	input  wire logic                          sync_present,
	input  wire logic signed [31:0]            time_diff_ns,
	input  wire logic                          time_traceable,
	input  wire logic [7:0]                    grandmaster_time_class,
	// Sample frame fields
	output logic                               smp_out_valid,
	output logic signed [NCH-1:0][SW-1:0]      smp_out,
	output logic      [NCH-1:0]                range_exceeded_flag,
	output logic      [NCH-1:0]                smp_questionable,
	output shq_src_t                           sample_sync_source,
	// Pulse control and status
	output logic                               sync_locked,
	output logic                               sync_alarm,
	output logic                               pps_slew_en,
	output logic                               pps_slew_dir,
	output logic                               pps_step,
	output logic signed [31:0]                 pps_step_ns,
	output logic                               op_mode,
	output logic                               in_service,
	output shq_health_t                        health
);

	shq_smp_if smp ();                   // Link to clip stage

	shq_sync_state_t state;              // Sync state
	shq_sync_state_t next_state;         // Next sync state
	logic            tick;               // Millisecond enable
	logic [31:0]     hold_count;         // Ticks spent in holdover
	logic            hold_done;          // Holdover expired
	logic [31:0]     diff_mag;           // Magnitude of time offset
	logic            diff_small;         // Below step limit
	logic            in_zone;            // Inside locked zone
	logic            cfg_received;       // First configuration seen
	logic [15:0]     nominal;            // Nominal current in counts
	logic [IRQ_W-1:0] irq_stat;          // Sticky events
	logic [IRQ_W-1:0] irq_mask;          // Event enables
	logic [IRQ_W-1:0] irq_event;         // Events this cycle
	logic [IRQ_W-1:0] irq_clr;           // Write-one-to-clear bits
	logic            any_quest;          // Latest set had a clip
	logic            wr_hit;             // Write decode helper

	// Clip stage wiring
	assign smp.in_valid = smp_in_valid;
	assign smp.in_data  = smp_in;
	assign smp.limit    = 24'({8'h00, nominal} * RANGE_MULT);

	shq_clip u_clip (
		.clk  (clk),
		.nrst (nrst),
		.smp  (smp)
	);

	shq_tick #(
		.DIV (TICK_CYCLES)
	) u_tick (
		.clk  (clk),
		.nrst (nrst),
		.tick (tick)
	);

	// Sample fields come straight from the clip stage registers
	assign smp_out_valid       = smp.out_valid;
	assign smp_out             = smp.out_data;
	assign range_exceeded_flag = smp.exceeded;
	assign smp_questionable    = smp.quest;
	assign any_quest           = |smp.quest;

	// Offset magnitude and comparisons
	assign diff_mag   = time_diff_ns[31] ? 32'(-time_diff_ns)
	                                     : 32'(time_diff_ns);
	assign diff_small = diff_mag < STEP_NS;
	assign in_zone    = diff_mag <= LOCK_ZONE_NS;
	assign hold_done  = tick && (hold_count >= 32'(HOLD_LEN - 1));

	// Next sync state
	always_comb begin
		next_state = state;
		unique case (state)
			SHQ_FREE: begin
				if (sync_present) begin
					// Small offsets are walked in, large ones stepped
					next_state = diff_small ? SHQ_SLEW
					                        : SHQ_LOCKED;
				end
			end
			SHQ_SLEW: begin
				if (!sync_present) begin
					next_state = SHQ_FREE;
				end else if (in_zone) begin
					next_state = SHQ_LOCKED;
				end
			end
			SHQ_LOCKED: begin
				if (!sync_present) begin
					next_state = SHQ_HOLD;
				end
			end
			SHQ_HOLD: begin
				if (sync_present) begin
					// Straight back to resync, timer abandoned
					next_state = diff_small ? SHQ_SLEW
					                        : SHQ_LOCKED;
				end else if (hold_done) begin
					next_state = SHQ_FREE;
				end
			end
		endcase
	end

	// Sync state register; free running until a reference appears
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= SHQ_FREE;
		end else begin
			state <= next_state;
		end
	end

	// Holdover timer counts ms ticks, cleared outside holdover
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hold_count <= 32'h0000_0000;
		end else if (state != SHQ_HOLD || sync_present) begin
			hold_count <= 32'h0000_0000;
		end else if (tick) begin
			hold_count <= hold_count + 32'h0000_0001;
		end
	end

	// Phase step pulse carries the offset to remove
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pps_step    <= 1'b0;
			pps_step_ns <= 32'sh0000_0000;
		end else begin
			pps_step <= (state == SHQ_FREE || state == SHQ_HOLD)
			            && sync_present && !diff_small;
			if ((state == SHQ_FREE || state == SHQ_HOLD) && sync_present) begin
				pps_step_ns <= time_diff_ns;
			end
		end
	end

	// Slew request: direction says internal time runs ahead
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pps_slew_en  <= 1'b0;
			pps_slew_dir <= 1'b0;
		end else begin
			pps_slew_en  <= next_state == SHQ_SLEW;
			pps_slew_dir <= !time_diff_ns[31];
		end
	end

	// Locked is reported through holdover too
	assign sync_locked = state == SHQ_LOCKED || state == SHQ_HOLD;
	assign sync_alarm  = state == SHQ_FREE;

	// Sample sync source from state, class and traceability
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sample_sync_source <= SHQ_SRC_NONE;
		end else if (!(next_state == SHQ_LOCKED || next_state == SHQ_HOLD)) begin
			sample_sync_source <= SHQ_SRC_NONE;
		end else if (grandmaster_time_class == CLASS_GLOBAL ||
		             (grandmaster_time_class == CLASS_TRACE &&
		              time_traceable)) begin
			sample_sync_source <= SHQ_SRC_GLOBAL;
		end else begin
			sample_sync_source <= SHQ_SRC_LOCAL;
		end
	end

	// Operation waits for the first configuration write
	assign op_mode    = cfg_received;
	assign in_service = cfg_received;

	// Health: warning on questionable samples or free running
	always_comb begin
		if (any_quest || state == SHQ_FREE) begin
			health = SHQ_WARNING;
		end else begin
			health = SHQ_OK;
		end
	end

	// Configuration and nominal registers
	assign wr_hit = reg_wr && !reg_rd;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_received <= 1'b0;
			nominal      <= NOMINAL_RST;
			irq_mask     <= IRQ_MASK_RST;
		end else if (wr_hit) begin
			// Configuration flag is sticky; only reset clears it
			if (reg_addr == REG_CTRL && reg_wdata[CTRL_CFG_BIT]) begin
				cfg_received <= 1'b1;
			end
			if (reg_addr == REG_NOMINAL) begin
				nominal <= reg_wdata[15:0];
			end
			if (reg_addr == REG_IRQ_MASK) begin
				irq_mask <= reg_wdata[IRQ_W-1:0];
			end
		end
	end

	// Events for the interrupt status
	always_comb begin
		irq_event            = '0;
		irq_event[IRQ_HOLD]  = state == SHQ_LOCKED && next_state == SHQ_HOLD;
		irq_event[IRQ_FREE]  = state == SHQ_HOLD && next_state == SHQ_FREE;
		irq_event[IRQ_RANGE] = smp.out_valid && |smp.exceeded;
		irq_event[IRQ_LOCK]  = state != SHQ_LOCKED && next_state == SHQ_LOCKED;
	end
	assign irq_clr = (wr_hit && reg_addr == REG_IRQ_STAT)
	                 ? reg_wdata[IRQ_W-1:0] : '0;

	// Sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_event;
		end
	end
	assign irq = |(irq_stat & irq_mask);

	// Read port; unmapped addresses and idle cycles read zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (!reg_rd) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			unique case (reg_addr)
				REG_CTRL:     reg_rdata <= {31'h0000_0000, cfg_received};
				REG_NOMINAL:  reg_rdata <= {16'h0000, nominal};
				REG_STATUS:   reg_rdata <= {20'h0_0000, health,
				                            sample_sync_source,
				                            sync_alarm, sync_locked,
				                            pps_slew_en, any_quest,
				                            2'b00, state};
				REG_IRQ_STAT: reg_rdata <= {28'h000_0000, irq_stat};
				REG_IRQ_MASK: reg_rdata <= {28'h000_0000, irq_mask};
				REG_RANGE:    reg_rdata <= {24'h00_0000, smp.exceeded};
				default:      reg_rdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule : shq_top

// [verification/shq_monitor.sv]
// Purpose: Port-level checks of sync state and sample quality
// Assumes: Bound to shq_top; a single clock domain
// Notes:   Holdover bound leaves a full tick of slack past a late start; early bound only eight cycles
`timescale 1ns/1ps
module shq_monitor
	import shq_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_DIV,
	parameter int unsigned HOLD_LEN = HOLD_TICKS
) (
	// Clock and reset
	input wire logic	clk,
	input wire logic	nrst,
	// Inputs watched
	input wire logic [AW-1:0]	reg_addr,
	input wire logic [31:0]	reg_wdata,
	input wire logic	reg_wr,
	input wire logic	smp_in_valid,
	input wire logic signed [NCH-1:0][SW-1:0]	smp_in,
	input wire logic	sync_present,
	input wire logic	time_traceable,
	input wire logic [7:0]	grandmaster_time_class,
	// Outputs watched
	input wire logic	smp_out_valid,
	input wire logic signed [NCH-1:0][SW-1:0]	smp_out,
	input wire logic [NCH-1:0]	range_exceeded_flag,
	input wire logic [NCH-1:0]	smp_questionable,
	input wire shq_src_t	sample_sync_source,
	input wire logic	sync_locked,
	input wire logic	sync_alarm,
	input wire logic	pps_step,
	input wire logic signed [31:0]	pps_step_ns,
	input wire logic	op_mode,
	input wire logic	in_service,
	input wire shq_health_t	health
);
	// Outlasts any holdover, even one that starts a tick late
	localparam int unsigned LOST_MAX = TICK_CYCLES * (HOLD_LEN + 2);
	int unsigned	lost_cnt;	// Clocks without a reference
	wire logic	glob = grandmaster_time_class == CLASS_GLOBAL ||
		(grandmaster_time_class == CLASS_TRACE && time_traceable);

	// Count absence of the reference, saturating past the bound
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			lost_cnt <= 0;
		else if (sync_present)
			lost_cnt <= 0;
		else if (lost_cnt <= LOST_MAX)
			lost_cnt <= lost_cnt + 1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_ans; smp_in_valid |=> smp_out_valid; endproperty
	a_ans: assert property (p_ans) else $error("sample not answered");
	property p_clip; smp_out_valid && range_exceeded_flag[0] |->
		smp_out[0] != $past(smp_in[0]); endproperty
	a_clip: assert property (p_clip) else $error("clip kept raw");
	property p_quest; smp_questionable == range_exceeded_flag; endproperty
	a_quest: assert property (p_quest) else $error("quality wrong");
	property p_hold; sync_locked && $fell(sync_present) |=>
		sync_locked [*8]; endproperty
	a_hold: assert property (p_hold) else $error("holdover short");
	property p_free; lost_cnt == LOST_MAX |-> sync_alarm && !sync_locked;
	endproperty
	a_free: assert property (p_free) else $error("no free run");
	property p_step; pps_step |-> sync_locked && (pps_step_ns >=
		int'(STEP_NS) || -pps_step_ns >= int'(STEP_NS)) ##1 !pps_step;
	endproperty
	a_step: assert property (p_step) else $error("bad phase step");
	property p_src; sync_locked && $stable(grandmaster_time_class) &&
		$stable(time_traceable) |-> sample_sync_source ==
		(glob ? SHQ_SRC_GLOBAL : SHQ_SRC_LOCAL); endproperty
	a_src: assert property (p_src) else $error("source wrong");
	property p_none; sync_alarm |-> sample_sync_source == SHQ_SRC_NONE;
	endproperty
	a_none: assert property (p_none) else $error("source not none");
	property p_cfg; $rose(in_service) |-> op_mode && $past(reg_wr) &&
		$past(reg_addr) == REG_CTRL && $past(reg_wdata[0]); endproperty
	a_cfg: assert property (p_cfg) else $error("early service");
	property p_keep; smp_out_valid && !range_exceeded_flag[0] |->
		smp_out[0] == $past(smp_in[0]); endproperty
	a_keep: assert property (p_keep) else $error("value altered");
	property p_heal; |smp_questionable |-> health == SHQ_WARNING; endproperty
	a_heal: assert property (p_heal) else $error("health not warn");

	c_step: cover property (pps_step);
	c_clip: cover property (smp_out_valid && |range_exceeded_flag);
	c_free: cover property (sync_locked ##1 sync_alarm);
endmodule : shq_monitor

bind shq_top shq_monitor #(
	.TICK_CYCLES(TICK_CYCLES),
	.HOLD_LEN(HOLD_LEN)
) u_mon (
	.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .smp_in_valid, .smp_in,
	.sync_present, .time_traceable, .grandmaster_time_class,
	.smp_out_valid, .smp_out, .range_exceeded_flag, .smp_questionable,
	.sample_sync_source, .sync_locked, .sync_alarm, .pps_step,
	.pps_step_ns, .op_mode, .in_service, .health
);

// [verification/shq_gm_model.sv]
// Purpose: Reference time source that follows the unit's pulse control
// Assumes: Bench drives it through tasks, just after clk rises
// Notes:   Offset is meaningless while absent, so it is inverted then
`timescale 1ns/1ps
module shq_gm_model
	import shq_pkg::*;
(
	// Clock and pulse control
	input wire logic	clk,
	input wire logic	pps_slew_en,
	input wire logic	pps_step,
	// Reference outputs
	output logic	sync_present,
	output logic signed [31:0]	time_diff_ns,
	output logic	time_traceable,
	output logic [7:0]	grandmaster_time_class
);
	logic signed [31:0]	diff;	// True offset of the unit's time

	initial begin
		sync_present = 1'b0;
		diff = 32'sh0;
		time_traceable = 1'b0;
		grandmaster_time_class = 8'h00;
	end
	// Never show a stale offset while the reference is missing
	assign time_diff_ns = sync_present ? diff : ~diff;
	// Offset follows the unit's corrections
	always @(posedge clk) begin
		if (pps_step)
			diff <= 32'sh0;
		else if (pps_slew_en)
			diff <= diff - (diff >>> 1);
	end
	// Present or remove the reference with an offset
	task automatic link(input logic on, input logic signed [31:0] d);
		@(posedge clk);
		sync_present <= on;
		diff <= d;
	endtask : link
	// Change clock class and traceability
	task automatic grade(input logic [7:0] c, input logic t);
		@(posedge clk);
		grandmaster_time_class <= c;
		time_traceable <= t;
	endtask : grade
endmodule : shq_gm_model

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the sync and sample quality block
// Assumes: Short tick and holdover parameters keep the run brief
// Notes:   Random samples from a fixed seed, clip corners mixed in
`timescale 1ns/1ps
module tb_top
	import shq_pkg::*;
;
	localparam int TCK = 4;	// Clocks per tick
	localparam int HLD = 5;	// Holdover ticks
	logic	clk, nrst, reg_wr, reg_rd, irq, smp_in_valid, smp_out_valid;
	logic [AW-1:0]	reg_addr;
	logic [31:0]	reg_wdata, reg_rdata, rv;
	logic signed [NCH-1:0][SW-1:0]	smp_in, smp_out, v;
	logic [NCH-1:0]	range_exceeded_flag, smp_questionable;
	shq_src_t	sample_sync_source;
	shq_health_t	health;
	logic	sync_present, time_traceable, sync_locked, sync_alarm;
	logic	pps_slew_en, pps_slew_dir, pps_step, op_mode, in_service;
	logic signed [31:0]	time_diff_ns, pps_step_ns;
	logic [7:0]	grandmaster_time_class;
	logic	ex, stepped, alarmed;	// Expected flag, pulses seen
	int	error_cnt = 0;
	int	checks = 0;
	int	seed = 94;
	int	lim, x[NCH];
	logic [15:0]	noms[2] = '{16'h1000, 16'h0200};
	logic [7:0]	cls[4] = '{8'h06, 8'h07, 8'h07, 8'h08};
	logic	trc[4] = '{1'b0, 1'b1, 1'b0, 1'b1};

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	shq_top #(.TICK_CYCLES(TCK), .HOLD_LEN(HLD)) dut (.clk, .nrst,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
		.smp_in_valid, .smp_in, .sync_present, .time_diff_ns,
		.time_traceable, .grandmaster_time_class, .smp_out_valid,
		.smp_out, .range_exceeded_flag, .smp_questionable,
		.sample_sync_source, .sync_locked, .sync_alarm, .pps_slew_en,
		.pps_slew_dir, .pps_step, .pps_step_ns, .op_mode, .in_service,
		.health);
	shq_gm_model gm (.clk, .pps_slew_en, .pps_step, .sync_present,
		.time_diff_ns, .time_traceable, .grandmaster_time_class);

	// Latch pulses that fall between the bench's sampling points
	always @(posedge clk) begin
		if (pps_step === 1'b1)
			stepped <= 1'b1;
		if (sync_alarm === 1'b1)
			alarmed <= 1'b1;
	end

	function automatic logic [SW-1:0] clip_of(input int a, input int l);
		return SW'(a > l ? l : (a < -l ? -l : a));
	endfunction : clip_of
	function automatic shq_src_t src_of(input logic [7:0] c, input logic t);
		return (c == CLASS_GLOBAL || (c == CLASS_TRACE && t)) ?
			SHQ_SRC_GLOBAL : SHQ_SRC_LOCAL;
	endfunction : src_of
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [AW-1:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd
	task automatic smp(input logic signed [NCH-1:0][SW-1:0] s);
		@(posedge clk);
		smp_in <= s;
		smp_in_valid <= 1'b1;
		@(posedge clk);
		smp_in_valid <= 1'b0;
		@(negedge clk);
	endtask : smp
	task automatic final_report();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report

	// Whole run is a few hundred clocks; cut a hang far beyond that
	initial begin
		#2_000_000;
		error_cnt++;
		final_report();
	end

	initial begin
		nrst = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		smp_in_valid = 1'b0;
		smp_in = '0;
		stepped = 1'b0;
		alarmed = 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		chk("in_service", 32'h0, 32'(in_service));
		chk("op_mode", 32'h0, 32'(op_mode));
		wr(REG_CTRL, 32'h0000_0001);
		@(negedge clk);
		chk("in_service", 32'h1, 32'(in_service));
		$display("test config done");
		// Clip corners first, then random sets around the limit
		foreach (noms[k]) begin
			lim = 40 * noms[k];
			wr(REG_NOMINAL, 32'(noms[k]));
			rd(REG_NOMINAL, rv);
			chk("nominal", 32'(noms[k]), rv);
			for (int i = 0; i < 12; i++) begin
				for (int c = 0; c < NCH; c++) begin
					x[c] = $random(seed) % (2 * lim);
					if (i == 0 && c < 4)
						x[c] = (c % 2 ? -1 : 1) * (lim + 1 - c / 2);
					v[c] = SW'(x[c]);
				end
				smp(v);
				chk("out_valid", 32'h1, 32'(smp_out_valid));
				for (int c = 0; c < NCH; c++) begin
					ex = x[c] > lim || x[c] < -lim;
					chk("flag", 32'(ex), 32'(range_exceeded_flag[c]));
					chk("quest", 32'(ex), 32'(smp_questionable[c]));
					chk("value", 32'(clip_of(x[c], lim)), 32'(smp_out[c]));
				end
				if (|range_exceeded_flag === 1'b1)
					chk("health", 32'(SHQ_WARNING), 32'(health));
			end
		end
		$display("test samples done");
		rd(REG_IRQ_STAT, rv);
		chk("irq_stat", 32'h1, 32'(rv[IRQ_RANGE]));
		chk("irq_masked", 32'h0, 32'(irq));
		wr(REG_IRQ_MASK, 32'h0000_0004);
		@(negedge clk);
		chk("irq_on", 32'h1, 32'(irq));
		wr(REG_IRQ_STAT, 32'h0000_0004);
		@(negedge clk);
		chk("irq_off", 32'h0, 32'(irq));
		rd(8'h20, rv);
		chk("unmapped", 32'h0, rv);
		$display("test irq done");
		// Small offset: slew into the locked zone, no step
		gm.link(1'b1, 32'sh003d_0900);
		repeat (3) @(negedge clk);
		chk("slew_en", 32'h1, 32'(pps_slew_en));
		chk("slew_dir", 32'h1, 32'(pps_slew_dir));
		chk("slew_lock", 32'h0, 32'(sync_locked));
		for (int n = 0; n < 100 && sync_locked !== 1'b1; n++)
			@(negedge clk);
		chk("locked", 32'h1, 32'(sync_locked));
		chk("no_step", 32'h0, 32'(stepped));
		smp('0);
		chk("health_ok", 32'(SHQ_OK), 32'(health));
		v[0] = 24'h7f_ffff;
		smp(v);
		chk("health_warn", 32'(SHQ_WARNING), 32'(health));
		foreach (cls[k]) begin
			gm.grade(cls[k], trc[k]);
			repeat (2) @(negedge clk);
			chk("source", 32'(src_of(cls[k], trc[k])),
				32'(sample_sync_source));
		end
		// Loss, then a large offset returns inside holdover
		alarmed = 1'b0;
		gm.link(1'b0, 32'sh0);
		repeat (10) @(negedge clk);
		chk("hold_lock", 32'h1, 32'(sync_locked));
		chk("hold_src", 32'(SHQ_SRC_LOCAL), 32'(sample_sync_source));
		gm.link(1'b1, 32'sh005b_8d80);
		repeat (5) @(negedge clk);
		chk("stepped", 32'h1, 32'(stepped));
		chk("step_ns", 32'h005b_8d80, pps_step_ns);
		chk("no_alarm", 32'h0, 32'(alarmed));
		chk("relock", 32'h1, 32'(sync_locked));
		// Loss that outlasts holdover
		gm.link(1'b0, 32'sh0);
		repeat (TCK * (HLD + 2) + 4) @(negedge clk);
		chk("free_alarm", 32'h1, 32'(sync_alarm));
		chk("free_src", 32'(SHQ_SRC_NONE), 32'(sample_sync_source));
		rd(REG_IRQ_STAT, rv);
		chk("irq_free", 32'h1, 32'(rv[IRQ_FREE]));
		$display("test sync done");
		final_report();
	end
endmodule : tb_top
